// file: hdl/pin_sync.sv
// three-stage synchroniser with second/third agreement for the enable pins
`timescale 1ns/1ps
module pin_sync (
  input  wire logic   i_ref_clk,              // reference clock
  input  wire logic   i_srst,                 // sync reset, active high
  input  wire logic   i_wlan_power_enable,    // raw wireless enable pin
  input  wire logic   i_radio_power_enable,   // raw radio enable pin
  regseq_sync_if.src  sync                    // filtered levels
);
  typedef struct packed {
    logic [2:0] w;
    logic [2:0] r;
    logic       w_lvl;
    logic       r_lvl;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // level changes only once stages two and three agree
  always_comb begin
    st_nxt   = st_r;
    st_nxt.w = {st_r.w[1:0], i_wlan_power_enable};
    st_nxt.r = {st_r.r[1:0], i_radio_power_enable};
    if (st_r.w[1] == st_r.w[2]) begin
      st_nxt.w_lvl = st_r.w[2];
    end
    if (st_r.r[1] == st_r.r[2]) begin
      st_nxt.r_lvl = st_r.r[2];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync.wlan_on  = st_r.w_lvl;
  assign sync.radio_on = st_r.r_lvl;
endmodule

// file: hdl/regseq_pkg.sv
// package of constants for the regulator enable and reset sequencer
// Function
// RULE1 - regulators on when either enable high
// RULE2 - wireless reset follows wireless enable low
// RULE3 - regulators off when both enables low
// RULE4 - radio held reset while radio enable low
// RULE5 - broadcast receiver shares radio reset
// RULE6 - power-on reset releases within 110 ms
// RULE7 - host waits 150 ms before bus access
// RULE8 - host spaces toggles 10 ms after both low
// RULE9 - host waits two sleep cycles before enabling; host_pins has no sleep clock and waits only its GAP idle cycles
package regseq_pkg;
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned POR_HOLD_MS   = 100;  // under the 110 ms ceiling
  localparam int unsigned POR_MAX_MS    = 110;
  localparam int unsigned POR_HOLD_CYC  = (CLK_HZ / 1000) * POR_HOLD_MS;
  localparam int unsigned POR_MAX_CYC   = (CLK_HZ / 1000) * POR_MAX_MS;
  localparam int unsigned DISCHARGE_MS  = 10;
  localparam int unsigned DISCHARGE_CYC = (CLK_HZ / 1000) * DISCHARGE_MS;
  localparam int unsigned SYNC_STAGES   = 3;
  localparam logic        RST_ASSERTED  = 1'b1;
endpackage

// file: hdl/regseq_sync_if.sv
// interface carrying synchronised enable levels to the sequencer core
`timescale 1ns/1ps
interface regseq_sync_if;
  logic wlan_on;
  logic radio_on;
  modport src (output wlan_on, output radio_on);
  modport dst (input wlan_on, input radio_on);
endinterface

// file: hdl/regulator_enable_reset_sequencer.sv
// regulator enable and per-section reset sequencer
`timescale 1ns/1ps
module regulator_enable_reset_sequencer #(
  parameter int unsigned POR_HOLD_CYC  = regseq_pkg::POR_HOLD_CYC,
  parameter int unsigned DISCHARGE_CYC = regseq_pkg::DISCHARGE_CYC
) (
  input  wire logic i_ref_clk,             // 25 MHz reference clock
  input  wire logic i_srst,                // sync reset, active high
  input  wire logic i_supplies_good,       // core and io supplies past threshold
  input  wire logic i_wlan_power_enable,   // host wireless enable pin
  input  wire logic i_radio_power_enable,  // host radio enable pin
  output logic      o_regulator_enable,    // internal regulators on
  output logic      o_por_active,          // internal power-on reset held
  output logic      o_wlan_reset,          // wireless section reset, high = reset
  output logic      o_radio_reset,         // radio and broadcast rx reset
  output logic      o_discharge_busy       // buck still discharging after off
);
  // counters are a full word; the longest hold at 25 MHz needs far fewer bits
  localparam int unsigned CW = 32;

  // refuse counts the logic cannot serve, at elaboration rather than in a run
  if (POR_HOLD_CYC < 1 || POR_HOLD_CYC > regseq_pkg::POR_MAX_CYC) begin : g_bad_hold
    $error("power-on hold count out of range");
  end
  if (DISCHARGE_CYC < 1) begin : g_bad_discharge
    $error("discharge count must be nonzero");
  end

  // next three-flop filter value: shift in the pin, move the level on agreement
  function automatic logic [3:0] filt_step(input logic [2:0] sh,
                                            input logic       lvl,
                                            input logic       pin);
    logic [3:0] res;
    res = {sh[1:0], pin, lvl};
    if (sh[1] == sh[2]) begin
      res[0] = sh[2];
    end
    return res;
  endfunction

  // a span counter has run out once it reaches its limit less one
  function automatic logic span_done(input logic [CW-1:0] cnt,
                                     input int unsigned   lim);
    return cnt >= CW'(lim - 1);
  endfunction

  regseq_sync_if sync_bus ();

  // pins are host-driven, so they cross into our clock here
  pin_sync u_sync (
    .i_ref_clk            (i_ref_clk),
    .i_srst               (i_srst),
    .i_wlan_power_enable  (i_wlan_power_enable),
    .i_radio_power_enable (i_radio_power_enable),
    .sync                 (sync_bus.src)
  );

  typedef struct packed {
    logic [2:0]    sup;
    logic          sup_lvl;
    logic [CW-1:0] por_cnt;
    logic          por;
    logic [CW-1:0] dis_cnt;
    logic          dis;
    logic          reg_en;
    logic          wl_rst;
    logic          rd_rst;
  } seq_state_t;

  seq_state_t st_r;
  seq_state_t st_nxt;

  logic any_on;

  // one combined enable for the regulators
  assign any_on = sync_bus.wlan_on | sync_bus.radio_on;  // [RULE1]

  always_comb begin
    st_nxt     = st_r;
    // supply-good is an analog level, filtered like the pins
    {st_nxt.sup, st_nxt.sup_lvl} = filt_step(st_r.sup, st_r.sup_lvl, i_supplies_good);
    // hold reset a fixed count after supplies settle, restart if they drop
    if (!st_r.sup_lvl) begin
      st_nxt.por     = 1'b1;
      st_nxt.por_cnt = '0;
    end else if (st_r.por) begin
      if (span_done(st_r.por_cnt, POR_HOLD_CYC)) begin
        st_nxt.por = 1'b0;  // [RULE6]
      end else begin
        st_nxt.por_cnt = st_r.por_cnt + CW'(1);
      end
    end
    // regulators follow the or, gated only by power-on reset
    st_nxt.reg_en = any_on & ~st_r.por;  // [RULE1] [RULE3]
    // section resets: each section needs its own enable and power-on reset released
    st_nxt.wl_rst = st_r.por | ~sync_bus.wlan_on;   // [RULE2]
    st_nxt.rd_rst = st_r.por | ~sync_bus.radio_on;  // [RULE4] [RULE5]
    // discharge window after regulators drop; flags only, host must respect it
    if (st_r.reg_en && !st_nxt.reg_en) begin
      st_nxt.dis     = 1'b1;  // [RULE8]
      st_nxt.dis_cnt = '0;
    end else if (st_r.dis) begin
      if (span_done(st_r.dis_cnt, DISCHARGE_CYC)) begin
        st_nxt.dis = 1'b0;
      end else begin
        st_nxt.dis_cnt = st_r.dis_cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_r        <= '0;
      st_r.por    <= regseq_pkg::RST_ASSERTED;
      st_r.wl_rst <= regseq_pkg::RST_ASSERTED;
      st_r.rd_rst <= regseq_pkg::RST_ASSERTED;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_regulator_enable = st_r.reg_en;
  assign o_por_active       = st_r.por;
  assign o_wlan_reset       = st_r.wl_rst;
  assign o_radio_reset      = st_r.rd_rst;
  assign o_discharge_busy   = st_r.dis;
endmodule

// file: testbench/host_pins.sv
// host gpio model driving the two enable pins
`timescale 1ns/1ps
module host_pins #(parameter int GAP = 10) (
  input  wire logic i_ref_clk,                   // clock
  input  wire logic i_wlan_req,                  // wants wlan
  input  wire logic i_radio_req,                 // wants radio
  output logic      o_wlan_power_enable  = 1'b0, // pin
  output logic      o_radio_power_enable = 1'b0  // pin
);
  int idle = 0;
  // once both pins are low, the next raise waits out the buck discharge
  always @(posedge i_ref_clk) begin
    if (o_wlan_power_enable || o_radio_power_enable) idle = 0;
    else if (idle < GAP) idle++;
    if (idle == 0 || idle == GAP) begin
      o_wlan_power_enable  <= i_wlan_req;
      o_radio_power_enable <= i_radio_req;
    end
  end
endmodule

// file: testbench/regseq_props.sv
// checker on the sequencer ports
`timescale 1ns/1ps
module regseq_props #(parameter int POR_HOLD_CYC = 20) (
  input wire logic i_ref_clk,            // clock
  input wire logic i_srst,               // reset
  input wire logic i_supplies_good,      // supplies
  input wire logic i_wlan_power_enable,  // pin
  input wire logic i_radio_power_enable, // pin
  input wire logic o_regulator_enable,   // regs
  input wire logic o_por_active,         // por
  input wire logic o_wlan_reset,         // reset
  input wire logic o_radio_reset,        // reset
  input wire logic o_discharge_busy      // busy
);
  localparam int REL_MAX = POR_HOLD_CYC + 8;
  wire w = i_wlan_power_enable;
  wire r = i_radio_power_enable;
  // eight quiet cycles cover the filter plus one output update
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  regs_on_a: assert property ((!o_por_active && (w || r))[*8] |-> o_regulator_enable)
    else $error("regulators off");
  regs_off_a: assert property ((!o_por_active && !w && !r)[*8] |-> !o_regulator_enable)
    else $error("regulators on");
  wlan_rst_a: assert property ((!o_por_active && $stable(w))[*8] |-> o_wlan_reset == !w)
    else $error("wlan reset wrong");
  radio_hold_a: assert property ((w && !r)[*8] |-> o_radio_reset)
    else $error("radio released");
  radio_run_a: assert property ((!o_por_active && r)[*8] |-> !o_radio_reset)
    else $error("radio held");
  por_hold_a: assert property (o_por_active && $past(o_por_active) |-> !o_regulator_enable)
    else $error("regulators on in por");
  por_rel_a: assert property ($rose(i_supplies_good) |-> ##[1:REL_MAX] !o_por_active)
    else $error("por too long");
  por_resets_a: assert property (o_por_active && $past(o_por_active)
    |-> o_wlan_reset && o_radio_reset) else $error("section out of reset in por");
  drop_flag_a: assert property ($fell(o_regulator_enable) |-> o_discharge_busy)
    else $error("discharge not flagged");
  sup_drop_a: assert property ((!i_supplies_good)[*8] |-> o_por_active)
    else $error("por not restarted");
endmodule
bind regulator_enable_reset_sequencer regseq_props #(.POR_HOLD_CYC(POR_HOLD_CYC)) props (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_supplies_good(i_supplies_good),
  .i_wlan_power_enable(i_wlan_power_enable), .i_radio_power_enable(i_radio_power_enable),
  .o_regulator_enable(o_regulator_enable), .o_por_active(o_por_active),
  .o_wlan_reset(o_wlan_reset), .o_radio_reset(o_radio_reset), .o_discharge_busy(o_discharge_busy));

// file: testbench/tb.sv
// self-checking bench for the sequencer
`timescale 1ns/1ps
module tb;
  localparam int HOLD = 20;
  localparam int DISC = 10;
  localparam int ACCESS = HOLD * 3 / 2;  // 150 ms host wait against the 100 ms hold
  logic clk = 1'b0, srst = 1'b1, sup = 1'b0, wq = 1'b1, rq = 1'b0;
  logic w, r, reg_en, por, w_rst, r_rst, busy;
  int failures = 0, checks_done = 0, n;
  always #20 clk = ~clk;
  host_pins #(.GAP(DISC)) host (.i_ref_clk(clk), .i_wlan_req(wq), .i_radio_req(rq),
    .o_wlan_power_enable(w), .o_radio_power_enable(r));
  regulator_enable_reset_sequencer #(.POR_HOLD_CYC(HOLD), .DISCHARGE_CYC(DISC)) dut (
    .i_ref_clk(clk), .i_srst(srst), .i_supplies_good(sup), .i_wlan_power_enable(w),
    .i_radio_power_enable(r), .o_regulator_enable(reg_en), .o_por_active(por),
    .o_wlan_reset(w_rst), .o_radio_reset(r_rst), .o_discharge_busy(busy));
  task automatic tick(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(string nm, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait while por (pick 0) or busy (pick 1) stays high; running out ends the run
  task automatic wait_hi(input bit pick, input int lim);
    n = 0;
    while ((pick ? busy : por) === 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (n == lim) begin
      failures++;
      stop_test();
    end
  endtask
  // pins are ignored until the hold runs out; release must not come early or late
  task automatic por_start();
    sup = 1'b1;
    tick(8);
    chk("regs in por", 1'b0, reg_en);
    wait_hi(1'b0, HOLD + 8);
    chk("por span", 1'b1, n + 8 >= HOLD && n <= HOLD);
    tick(ACCESS - 8 - n);
  endtask
  // supplies dip with wlan up: power-on reset restarts and forces everything off
  task automatic supply_dip();
    wq = 1'b1;
    tick(12);
    chk("regs before dip", 1'b1, reg_en);
    sup = 1'b0;
    tick(8);
    chk("por restart", 1'b1, por);
    chk("wlan reset in dip", 1'b1, w_rst);
    chk("busy after dip", 1'b1, busy);
    por_start();
    chk("regs after dip", 1'b1, reg_en);
    chk("wlan reset after dip", 1'b0, w_rst);
  endtask
  // every pin pairing, radio dropped while wlan stays up on the way
  task automatic pin_table();
    logic [1:0] t [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    foreach (t[i]) begin
      {wq, rq} = t[i];
      tick(12);
      chk("regs", |t[i], reg_en);
      chk("wlan reset", !t[i][1], w_rst);
      chk("radio reset", !t[i][0], r_rst);
    end
  endtask
  // regulators drop with both pins low and the discharge flag covers the window
  task automatic discharge();
    wq = 1'b1;
    tick(12);
    wq = 1'b0;
    tick(6);
    chk("regs off", 1'b0, reg_en);
    wait_hi(1'b1, 4 * DISC);
    chk("busy span", 1'b1, n + 4 >= DISC && n <= DISC);
  endtask
  initial begin
    tick(6);
    srst = 1'b0;
    por_start();
    pin_table();
    discharge();
    supply_dip();
    stop_test();
  end
endmodule
